// *** design/dbfx_datapath.sv ***
/*
 * Execute stage for doubleword bit-field extract (lower, middle, upper) and lower insert.
 * Assumes decode gives the instruction word with both source operands read from the
 * register file in the same cycle, and the register file takes the write one cycle later.
 */
`timescale 1ns/100ps
module dbfx_datapath
    import dbfx_pkg::*;
#(
    parameter bit RELEASE2 = 1'b1
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // issue from decode
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [63:0] i_src_data,
    input wire logic [63:0] i_tgt_data,
    // result to register file, reserved-instruction exception and hit flag
    output logic o_wr_en,
    output logic [4:0] o_wr_addr,
    output logic [63:0] o_wr_data,
    output logic o_ri_exc,
    output logic o_hit
);

    // the five-bit fields must tile the word below the major code
    if (DBFX_TARGET_LSB != DBFX_SOURCE_LSB + 5 || DBFX_SOURCE_LSB != DBFX_TOP_LSB + 5
        || DBFX_TOP_LSB != DBFX_LOW_LSB + 5 || DBFX_MAJOR_LSB != DBFX_TARGET_LSB + 5) begin : g_bad_layout
        $error("instruction field layout does not tile the word");
    end
    // the result is registered exactly once and the word offset is half the doubleword
    if (DBFX_LATENCY != 1 || DBFX_WORD_OFFSET != 7'h20) begin : g_bad_timing
        $error("only a one-cycle result on a 64-bit doubleword is served");
    end

    // minor code decode, shared by hit and kind logic
    function automatic dbfx_kind_t dbfx_decode(input logic [31:0] w);
        dbfx_kind_t k;
        k = DBFX_OP_NONE;
        if (w[31:DBFX_MAJOR_LSB] == DBFX_MAJOR_GROUP_S) begin
            case (w[5:0])
                DBFX_MINOR_EXT_LOWER, DBFX_MINOR_EXT_MIDDLE, DBFX_MINOR_EXT_UPPER: k = DBFX_OP_EXTRACT;
                DBFX_MINOR_INS_LOWER: k = DBFX_OP_INSERT;
                default: k = DBFX_OP_NONE;
            endcase
        end
        return k;
    endfunction

    dbfx_kind_t kind;
    logic [4:0] top_enc;
    logic [4:0] low_enc;
    logic [6:0] top_idx;
    logic [6:0] low_idx;
    logic [63:0] width_mask;
    logic [63:0] result;
    logic wr_en_next, ri_next;
    logic [4:0] wr_addr_next;
    logic [63:0] wr_data_next;
    logic wr_en_reg, ri_reg;
    logic [4:0] wr_addr_reg;
    logic [63:0] wr_data_reg;

    assign kind = dbfx_decode(i_instr);
    assign top_enc = i_instr[DBFX_TOP_LSB +: 5];
    assign low_enc = i_instr[DBFX_LOW_LSB +: 5];
    assign o_hit = i_valid && (kind != DBFX_OP_NONE);

    always_comb begin
        top_idx = {2'b00, top_enc};
        low_idx = {2'b00, low_enc};
        width_mask = 64'h0;
        result = 64'h0;
        if (i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE) begin
            top_idx = {2'b00, top_enc} + DBFX_WORD_OFFSET;
        end
        if (i_instr[5:0] == DBFX_MINOR_EXT_UPPER) begin
            low_idx = {2'b00, low_enc} + DBFX_WORD_OFFSET;
        end
        if (kind == DBFX_OP_EXTRACT) begin
            // top_idx is size-1; mask of size ones, 64-bit field included
            width_mask = (top_idx[6:0] == 7'h3F) ? 64'hFFFFFFFFFFFFFFFF
                         : ((64'h1 << (top_idx[5:0] + 6'h01)) - 64'h1);
            result = (i_src_data >> low_idx[5:0]) & width_mask;
        end else if (kind == DBFX_OP_INSERT) begin
            // field lsb..msb inside low word; lsb above msb left unpredictable
            width_mask = ((64'h1 << (top_idx[5:0] + 6'h01)) - 64'h1)
                         & ~((64'h1 << low_idx[5:0]) - 64'h1);
            result = (i_tgt_data & ~width_mask) | ((i_src_data << low_idx[5:0]) & width_mask);
        end
    end

    always_comb begin
        wr_en_next = 1'b0;
        ri_next = 1'b0;
        wr_addr_next = i_instr[DBFX_TARGET_LSB +: 5];
        wr_data_next = wr_data_reg;
        if (o_hit) begin
            if (!RELEASE2) begin
                ri_next = 1'b1;
            end else begin
                wr_en_next = 1'b1;
                wr_data_next = result;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_en_reg <= 1'b0;
            ri_reg <= 1'b0;
            wr_addr_reg <= 5'h00;
            wr_data_reg <= 64'h0;
        end else begin
            wr_en_reg <= wr_en_next;
            ri_reg <= ri_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign o_wr_en = wr_en_reg;
    assign o_wr_addr = wr_addr_reg;
    assign o_wr_data = wr_data_reg;
    assign o_ri_exc = ri_reg;

    a_ext_zero_fill: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_EXTRACT && i_instr[5:0] != DBFX_MINOR_EXT_MIDDLE)
        |=> ((o_wr_data >> 32) == 64'h0))
        else $error("extract upper word not zero");
    a_ins_keep_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_INSERT)
        |=> (o_wr_data[63:32] == $past(i_tgt_data[63:32])))
        else $error("insert altered high word");
    a_upper_ext_val: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_UPPER && i_instr[15:11] == 5'h00)
        |=> (o_wr_data == {63'h0, $past(i_src_data[32 + i_instr[10:6]])}))
        else $error("upper extract offset wrong");
    a_mid_ext_val: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE && i_instr[15:6] == 10'h3E0)
        |=> (o_wr_data == $past(i_src_data)))
        else $error("middle extract full width wrong");
    a_ri_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ri_exc |-> !o_wr_en)
        else $error("write during reserved instruction");
    a_ri_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && !RELEASE2) |=> o_ri_exc)
        else $error("reserved instruction missed");
    a_wr_target: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_hit |=> (o_wr_addr == $past(i_instr[25:21])))
        else $error("write address not target field");
    a_only_hits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_hit |=> (!o_wr_en && !o_ri_exc))
        else $error("spurious write or exception");

    c_ext_lower: cover property (@(posedge i_clk_sys) o_hit && i_instr[5:0] == DBFX_MINOR_EXT_LOWER);
    c_ext_middle: cover property (@(posedge i_clk_sys) o_hit && i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE);
    c_ext_upper: cover property (@(posedge i_clk_sys) o_hit && i_instr[5:0] == DBFX_MINOR_EXT_UPPER);
    c_ins_lower: cover property (@(posedge i_clk_sys) o_hit && i_instr[5:0] == DBFX_MINOR_INS_LOWER);
    c_old_reserved: cover property (@(posedge i_clk_sys) o_ri_exc);

    // bitwise shadow of the datapath, built per bit instead of by shifts, for the checks below
    logic [6:0] chk_top;
    logic [6:0] chk_low;
    logic [63:0] chk_ext;
    logic [63:0] chk_ins;
    logic chk_legal;

    assign chk_top = (i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE) ? ({2'b00, i_instr[15:11]} + DBFX_WORD_OFFSET)
                     : {2'b00, i_instr[15:11]};
    assign chk_low = (i_instr[5:0] == DBFX_MINOR_EXT_UPPER) ? ({2'b00, i_instr[10:6]} + DBFX_WORD_OFFSET)
                     : {2'b00, i_instr[10:6]};
    // extract needs low + top + 1 within 64, insert needs lsb not above msb
    assign chk_legal = (kind == DBFX_OP_INSERT) ? (chk_low <= chk_top)
                       : (({1'b0, chk_low} + {1'b0, chk_top}) < 8'h40);

    for (genvar b = 0; b < 64; b++) begin : g_shadow
        logic [6:0] from_bit;
        assign from_bit = chk_low + 7'(b);
        assign chk_ext[b] = (7'(b) <= chk_top) && !from_bit[6] && i_src_data[from_bit[5:0]];
        assign chk_ins[b] = ((7'(b) >= chk_low) && (7'(b) <= chk_top)) ? i_src_data[6'(b) - chk_low[5:0]]
                            : i_tgt_data[b];
    end

    a_ext_shadow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_EXTRACT && chk_legal)
        |=> (o_wr_data == $past(chk_ext)))
        else $error("extract differs from bitwise shadow");

    a_ins_shadow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_INSERT && chk_legal)
        |=> (o_wr_data == $past(chk_ins)))
        else $error("insert differs from bitwise shadow");

    a_reset_quiet: assert property (@(posedge i_clk_sys)
        !i_rst_n
        |=> (!o_wr_en && !o_ri_exc && o_wr_addr == 5'h00 && o_wr_data == 64'h0))
        else $error("outputs not cleared by reset");

    a_hit_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2)
        |=> o_wr_en)
        else $error("handled instruction not written");

    a_hold_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!o_hit || !RELEASE2)
        |=> $stable(o_wr_data))
        else $error("result changed without a write");

    a_old_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !RELEASE2
        |-> !o_wr_en)
        else $error("older core wrote a result");

    a_ri_only_old: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ri_exc
        |-> !RELEASE2)
        else $error("reserved instruction on current core");

    a_old_data_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !RELEASE2
        |-> (o_wr_data == 64'h0))
        else $error("older core moved result data");

    a_hit_major: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_hit
        |-> (i_instr[31:26] == DBFX_MAJOR_GROUP_S))
        else $error("hit outside the major group");

    a_hit_valid: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_hit
        |-> i_valid)
        else $error("hit without valid");

    a_ins_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_valid && i_instr[31:26] == DBFX_MAJOR_GROUP_S && i_instr[5:0] == DBFX_MINOR_INS_LOWER)
        |-> (o_hit && kind == DBFX_OP_INSERT))
        else $error("lower insert not decoded");

    a_upper_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_valid && i_instr[31:26] == DBFX_MAJOR_GROUP_S && i_instr[5:0] == DBFX_MINOR_EXT_UPPER)
        |-> (o_hit && kind == DBFX_OP_EXTRACT))
        else $error("upper extract not decoded");

    a_mid_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_valid && i_instr[31:26] == DBFX_MAJOR_GROUP_S && i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE)
        |-> (o_hit && kind == DBFX_OP_EXTRACT))
        else $error("middle extract not decoded");

    a_mid_top_32: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_MIDDLE && i_instr[15:6] == 10'h01F)
        |=> (o_wr_data == {31'h0, $past(i_src_data[63:31])}))
        else $error("middle extract of 33 bits wrong");

    a_upper_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_UPPER && i_instr[15:6] == 10'h3E0)
        |=> (o_wr_data == {32'h0, $past(i_src_data[63:32])}))
        else $error("upper extract of high word wrong");

    a_lower_one_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_LOWER && i_instr[15:11] == 5'h00)
        |=> (o_wr_data[63:1] == 63'h0))
        else $error("one-bit extract not zero filled");

    a_lower_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && i_instr[5:0] == DBFX_MINOR_EXT_LOWER && i_instr[15:6] == 10'h3FF)
        |=> (o_wr_data == {32'h0, $past(i_src_data[62:31])}))
        else $error("lower extract of 32 bits wrong");

    a_ins_low_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_INSERT && i_instr[10:6] != 5'h00 && chk_legal)
        |=> (o_wr_data[0] == $past(i_tgt_data[0])))
        else $error("insert altered bit below field");

    a_ins_top_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_INSERT && i_instr[15:11] != 5'h1F && chk_legal)
        |=> (o_wr_data[31] == $past(i_tgt_data[31])))
        else $error("insert altered bit above field");

    a_ins_field_lsb: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_hit && RELEASE2 && kind == DBFX_OP_INSERT && chk_legal)
        |=> (o_wr_data[$past(i_instr[10:6])] == $past(i_src_data[0])))
        else $error("insert field lsb not source bit 0");

endmodule // dbfx_datapath

// *** design/dbfx_pkg.sv ***
/*
 * Constants for the doubleword bit-field extract/insert datapath: opcode fields,
 * minor codes, bit positions and offsets.
 * Assumes the decoder presents a full 32-bit instruction word.
 */
package dbfx_pkg;
    localparam logic [5:0] DBFX_MAJOR_GROUP_S = 6'h16;
    localparam logic [5:0] DBFX_MINOR_EXT_LOWER = 6'h2C;
    localparam logic [5:0] DBFX_MINOR_EXT_MIDDLE = 6'h24;
    localparam logic [5:0] DBFX_MINOR_EXT_UPPER = 6'h14;
    localparam logic [5:0] DBFX_MINOR_INS_LOWER = 6'h0C;
    localparam int DBFX_MAJOR_LSB = 26;
    localparam int DBFX_TARGET_LSB = 21;
    localparam int DBFX_SOURCE_LSB = 16;
    localparam int DBFX_TOP_LSB = 11;
    localparam int DBFX_LOW_LSB = 6;
    localparam logic [6:0] DBFX_WORD_OFFSET = 7'h20;
    localparam int DBFX_LATENCY = 1;
    typedef enum logic [1:0] {
        DBFX_OP_NONE = 2'b00,
        DBFX_OP_EXTRACT = 2'b01,
        DBFX_OP_INSERT = 2'b10
    } dbfx_kind_t;
endpackage

// *** test/dbfx_regfile_model.sv ***
/* register file model on the far side of the datapath
   assumes target and source numbers sit in bits 25..21 and 20..16 */
`timescale 1ns/100ps
module dbfx_regfile_model (
    // clock
    input wire logic i_clk_sys,
    // read and write
    input wire logic [31:0] i_instr,
    input wire logic i_wr_en,
    input wire logic [4:0] i_wr_addr,
    input wire logic [63:0] i_wr_data,
    output logic [63:0] o_src_data,
    output logic [63:0] o_tgt_data
);
    logic [63:0] regs [32];
    assign o_src_data = regs[i_instr[20:16]];
    assign o_tgt_data = regs[i_instr[25:21]];
    always @(posedge i_clk_sys) begin
        if (i_wr_en) begin
            regs[i_wr_addr] <= i_wr_data;
        end
    end
endmodule // dbfx_regfile_model

// *** test/dbfx_datapath_tb.sv ***
/* self-checking bench for the bit-field datapath, current and pre-release-2 cores side by side
   assumes the register file model answers reads in the issue cycle */
`timescale 1ns/100ps
module dbfx_datapath_tb;
    import dbfx_pkg::*;
    logic i_clk_sys, i_rst_n, i_valid, wr_en, ri_exc, hit, old_wr_en, old_ri_exc;
    logic [31:0] i_instr;
    logic [63:0] src_data, tgt_data, wr_data;
    logic [4:0] wr_addr;
    int miscompares = 0;
    int total_checks = 0;
    localparam logic [63:0] SRC = 64'hF0E1D2C3B4A59687;
    localparam logic [63:0] TGT = 64'h0123456789ABCDEF;
    dbfx_datapath dbfx_datapath_i (.i_clk_sys, .i_rst_n, .i_valid, .i_instr, .i_src_data(src_data),
        .i_tgt_data(tgt_data), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_ri_exc(ri_exc), .o_hit(hit));
    dbfx_datapath #(.RELEASE2(1'b0)) dbfx_datapath_old_i (.i_clk_sys, .i_rst_n, .i_valid, .i_instr,
        .i_src_data(src_data), .i_tgt_data(tgt_data), .o_wr_en(old_wr_en), .o_wr_addr(), .o_wr_data(),
        .o_ri_exc(old_ri_exc), .o_hit());
    dbfx_regfile_model dbfx_regfile_model_i (.i_clk_sys, .i_instr, .i_wr_en(wr_en), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_src_data(src_data), .o_tgt_data(tgt_data));
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [63:0] mask(int size);
        return (size >= 64) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << size) - 64'h1;
    endfunction
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic issue(logic [5:0] minor, int top, int low, logic exp_hit);
        i_valid = 1'b1;
        i_instr = {DBFX_MAJOR_GROUP_S, 5'h05, 5'h03, top[4:0], low[4:0], minor};
        #1 chk(64'(hit), 64'(exp_hit));
        @(negedge i_clk_sys);
    endtask
    task automatic written(logic [63:0] exp);
        chk(64'({wr_en, ri_exc, old_wr_en, old_ri_exc, wr_addr}), 64'({4'h9, 5'h05}));
        chk(wr_data, exp);
    endtask
    task automatic idle;
        i_valid = 1'b0;
        @(negedge i_clk_sys);
        chk(64'({wr_en, ri_exc, old_ri_exc}), 64'h0);
    endtask
    task automatic test_extract;
        int p[7] = '{0, 31, 0, 31, 32, 32, 63};
        int s[7] = '{1, 32, 64, 33, 1, 32, 1};
        // boundary fields of each form, issued back to back
        for (int i = 0; i < 7; i++) begin
            if (p[i] >= 32) issue(DBFX_MINOR_EXT_UPPER, s[i] - 1, p[i] - 32, 1'b1);
            else if (s[i] > 32) issue(DBFX_MINOR_EXT_MIDDLE, s[i] - 33, p[i], 1'b1);
            else issue(DBFX_MINOR_EXT_LOWER, s[i] - 1, p[i], 1'b1);
            written((SRC >> p[i]) & mask(s[i]));
        end
        idle();
        $display("test extract done");
    endtask
    task automatic test_insert;
        int p[4] = '{0, 0, 31, 7};
        int s[4] = '{1, 32, 1, 9};
        for (int i = 0; i < 4; i++) begin
            dbfx_regfile_model_i.regs[5] = TGT;
            issue(DBFX_MINOR_INS_LOWER, p[i] + s[i] - 1, p[i], 1'b1);
            written((TGT & ~(mask(s[i]) << p[i])) | ((SRC & mask(s[i])) << p[i]));
            idle();
        end
        $display("test insert done");
    endtask
    task automatic test_ignored;
        issue(6'h3F, 0, 0, 1'b0);
        chk(64'({wr_en, old_ri_exc}), 64'h0);
        idle();
        $display("test ignored done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        i_rst_n = 1'b0;
        i_valid = 1'b0;
        i_instr = 32'h0;
        dbfx_regfile_model_i.regs[3] = SRC;
        repeat (12) @(negedge i_clk_sys);
        chk(64'({wr_en, ri_exc}), 64'h0);
        i_rst_n = 1'b1;
        test_extract();
        test_insert();
        test_ignored();
        test_done();
    end
endmodule // dbfx_datapath_tb
